//--- hw/rcoc_pkg.sv
/*
 * Constants for the radio control and offset compensation configuration bank:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 100 MHz system clock and a 6-bit register address.
 */
package rcoc_pkg;
    localparam logic [5:0] RCOC_ADDR_SM_CFG0 = 6'h18;
    localparam logic [5:0] RCOC_ADDR_FOC_CFG = 6'h19;

    localparam logic [7:0] RCOC_SM_CFG0_RST = 8'h04;
    localparam logic [7:0] RCOC_FOC_CFG_RST = 8'h36;
    localparam logic [7:0] RCOC_SM_CFG0_MASK = 8'h3F;
    localparam logic [7:0] RCOC_FOC_CFG_MASK = 8'h3F;

    // radio_control_sm_cfg0 fields
    localparam int RCOC_AUTOCAL_LSB = 4;
    localparam int RCOC_PO_TMO_LSB = 2;
    localparam int RCOC_PIN_CTRL_BIT = 1;
    localparam int RCOC_XOSC_ON_BIT = 0;

    // freq_offset_comp_cfg fields
    localparam int RCOC_FREEZE_BIT = 5;
    localparam int RCOC_PRE_K_LSB = 3;
    localparam int RCOC_POST_K_BIT = 2;
    localparam int RCOC_LIMIT_LSB = 0;

    typedef enum logic [1:0] {
        RCOC_CAL_NEVER,
        RCOC_CAL_ON_ENTRY,
        RCOC_CAL_ON_RETURN,
        RCOC_CAL_EVERY_4TH
    } rcoc_cal_mode_t;

    // expiries of the 6-bit ripple counter per timeout setting
    localparam logic [8:0] RCOC_PO_EXP_0 = 9'h001;
    localparam logic [8:0] RCOC_PO_EXP_1 = 9'h010;
    localparam logic [8:0] RCOC_PO_EXP_2 = 9'h040;
    localparam logic [8:0] RCOC_PO_EXP_3 = 9'h100;

    // one ripple step lasts one crystal period
    localparam int RCOC_CLK_PERIOD_NS = 10;
    localparam int RCOC_RIPPLE_STEP_NS = 38;
    localparam int RCOC_RIPPLE_STEP_CYC =
        (RCOC_RIPPLE_STEP_NS + RCOC_CLK_PERIOD_NS - 1) / RCOC_CLK_PERIOD_NS;

    localparam int RCOC_OFS_W = 12;
endpackage : rcoc_pkg

//--- hw/rcoc_po_timer.sv
/*
 * Power-on timeout: after the oscillator is stable, counts expiries of a
 * 6-bit ripple counter and then drives the active-low chip-ready output low.
 * Assumes xosc_ok is already synchronised to clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
module rcoc_po_timer
    import rcoc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic xosc_ok,
    input wire logic [1:0] tmo_sel,
    output logic chip_ready_n
);
    logic [7:0] step_cnt_r;
    logic step_en;
    logic [5:0] ripple_r;
    logic [8:0] expire_r;
    logic [8:0] expire_goal;

    assign step_en = (step_cnt_r == 8'(RCOC_RIPPLE_STEP_CYC - 1));

    always_comb begin
        case (tmo_sel)
            2'h0: expire_goal = RCOC_PO_EXP_0;
            2'h1: expire_goal = RCOC_PO_EXP_1;
            2'h2: expire_goal = RCOC_PO_EXP_2;
            default: expire_goal = RCOC_PO_EXP_3;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst || !xosc_ok || step_en) begin
            step_cnt_r <= 8'h00;
        end else begin
            step_cnt_r <= step_cnt_r + 8'h01;
        end
    end

    // losing the oscillator restarts the whole timeout
    always_ff @(posedge clk_sys) begin
        if (srst || !xosc_ok) begin
            ripple_r <= 6'h00;
            expire_r <= 9'h000;
        end else if (step_en && expire_r < expire_goal) begin
            ripple_r <= ripple_r + 6'h01;
            if (ripple_r == 6'h3F) begin
                expire_r <= expire_r + 9'h001; // see R6
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || !xosc_ok) begin
            chip_ready_n <= 1'b1;
        end else if (expire_r >= expire_goal) begin
            chip_ready_n <= 1'b0; // see R6
        end
    end
endmodule : rcoc_po_timer
`default_nettype wire

//--- hw/rcoc_cfg.sv
/*
 * Radio control state machine configuration and frequency offset
 * compensation configuration, with the control they select: synthesizer
 * auto-calibration, power-on chip-ready timeout, pin radio control,
 * oscillator keep-on in sleep, and offset loop gain, freeze and saturation.
 * Assumes the radio state machine reports transitions as one-cycle pulses
 * on clk_sys, and that pins and the oscillator-stable flag are asynchronous.
 */
// What this block does
// R1: with auto-calibration select 00 the synthesizer calibrates only on the calibrate strobe.
// R2: with select 01 it calibrates on every move from idle into receive, transmit or tx-ready.
// R3: with select 10 it calibrates on every automatic return from receive or transmit to idle.
// R4: with select 11 it calibrates on every fourth automatic return to idle and on the calibrate strobe.
// R5: a two-bit counter, cleared by reset, counts those returns and calibration fires when it wraps.
// R6: chip-ready goes low only after the ripple counter expired 1, 16, 64 or 256 times.
// R7: software should program the power-on timeout to 2, using 0 only in safe conditions.
// R8: with pin radio control enabled, radio state requests are taken from the pins.
// R9: with oscillator keep-on set, the crystal oscillator stays running in sleep.
// R10: with loop freeze set, offset and clock recovery loops stay frozen until carrier sense rises.
// R11: before sync the compensation gain is K, 2K, 3K or 4K by the pre-sync field.
// R12: after sync the gain stays as before sync when the post bit is 0, else it is K/2.
// R13: the compensation saturates at zero, an eighth, a quarter or a half of channel bandwidth.
// R14: software must set the saturation limit to zero when on-off keying is used.
`timescale 1ns/10ps
`default_nettype none
module rcoc_cfg
    import rcoc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    // register port
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    // radio state machine events
    input wire logic calibrate_strobe,
    input wire logic evt_idle_to_active,
    input wire logic evt_auto_return_idle,
    input wire logic in_sleep_state,
    output logic cal_start,
    // oscillator and chip-ready
    input wire logic xosc_stable,
    output logic xosc_enable,
    output logic chip_ready_indicator_n,
    // pin radio control
    input wire logic pin_rx_req,
    input wire logic pin_tx_req,
    output logic pin_rx_go,
    output logic pin_tx_go,
    output logic pin_ctrl_active,
    // demodulator
    input wire logic rx_start,
    input wire logic carrier_sense,
    input wire logic sync_found,
    input wire logic signed [RCOC_OFS_W-1:0] ofs_estimate,
    input wire logic [RCOC_OFS_W-1:0] chan_bw,
    output logic loop_freeze,
    output logic [3:0] comp_gain_half_k,
    output logic comp_enable,
    output logic signed [RCOC_OFS_W-1:0] ofs_applied
);
    logic [7:0] sm_cfg0_r;
    logic [7:0] foc_cfg_r;

    rcoc_cal_mode_t cal_mode;
    logic [1:0] po_tmo_sel;
    logic pin_ctrl_en;
    logic xosc_force_on;
    logic freeze_gate;
    logic [1:0] pre_k_sel;
    logic post_k_half;
    logic [1:0] limit_sel;

    assign cal_mode = rcoc_cal_mode_t'(sm_cfg0_r[RCOC_AUTOCAL_LSB +: 2]);
    assign po_tmo_sel = sm_cfg0_r[RCOC_PO_TMO_LSB +: 2];
    assign pin_ctrl_en = sm_cfg0_r[RCOC_PIN_CTRL_BIT];
    assign xosc_force_on = sm_cfg0_r[RCOC_XOSC_ON_BIT];
    assign freeze_gate = foc_cfg_r[RCOC_FREEZE_BIT];
    assign pre_k_sel = foc_cfg_r[RCOC_PRE_K_LSB +: 2];
    assign post_k_half = foc_cfg_r[RCOC_POST_K_BIT];
    assign limit_sel = foc_cfg_r[RCOC_LIMIT_LSB +: 2];

    // register writes; reserved bits never store
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sm_cfg0_r <= RCOC_SM_CFG0_RST;
        end else if (reg_wr_en && reg_addr == RCOC_ADDR_SM_CFG0) begin
            sm_cfg0_r <= reg_wr_data & RCOC_SM_CFG0_MASK;
        end
    end

    // the limit field is stored as written, even with on-off keying
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            foc_cfg_r <= RCOC_FOC_CFG_RST;
        end else if (reg_wr_en && reg_addr == RCOC_ADDR_FOC_CFG) begin
            foc_cfg_r <= reg_wr_data & RCOC_FOC_CFG_MASK; // see R14
        end
    end

    // reads answer one cycle later; unmapped addresses read zero
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rd_data <= 8'h00;
        end else if (reg_rd_en) begin
            case (reg_addr)
                RCOC_ADDR_SM_CFG0: reg_rd_data <= sm_cfg0_r;
                RCOC_ADDR_FOC_CFG: reg_rd_data <= foc_cfg_r;
                default: reg_rd_data <= 8'h00;
            endcase
        end
    end

    // automatic calibration
    logic [1:0] return_cnt_r;
    logic cal_nxt;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            return_cnt_r <= 2'h0;
        end else if (cal_mode == RCOC_CAL_EVERY_4TH && evt_auto_return_idle) begin
            return_cnt_r <= return_cnt_r + 2'h1; // see R5
        end
    end

    // the manual strobe calibrates in every mode, not only in 00
    always_comb begin
        cal_nxt = calibrate_strobe; // see R1
        case (cal_mode)
            RCOC_CAL_NEVER: cal_nxt = calibrate_strobe; // see R1
            RCOC_CAL_ON_ENTRY: begin
                if (evt_idle_to_active) begin
                    cal_nxt = 1'b1; // see R2
                end
            end
            RCOC_CAL_ON_RETURN: begin
                if (evt_auto_return_idle) begin
                    cal_nxt = 1'b1; // see R3
                end
            end
            RCOC_CAL_EVERY_4TH: begin
                // fires on the return that wraps the counter from 3 to 0
                if (evt_auto_return_idle && return_cnt_r == 2'h3) begin
                    cal_nxt = 1'b1; // see R4
                end
            end
            default: cal_nxt = calibrate_strobe;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cal_start <= 1'b0;
        end else begin
            cal_start <= cal_nxt;
        end
    end

    // oscillator stable flag crosses in from the analog side
    logic xosc_meta_r;
    logic xosc_sync_r;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            xosc_meta_r <= 1'b0;
            xosc_sync_r <= 1'b0;
        end else begin
            xosc_meta_r <= xosc_stable;
            xosc_sync_r <= xosc_meta_r;
        end
    end

    // the timeout select is taken live; software sets it before wake-up
    rcoc_po_timer u_po_timer (
        .clk_sys(clk_sys),
        .srst(srst),
        .xosc_ok(xosc_sync_r),
        .tmo_sel(po_tmo_sel), // see R7
        .chip_ready_n(chip_ready_indicator_n)
    );

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            xosc_enable <= 1'b1;
        end else begin
            xosc_enable <= !in_sleep_state || xosc_force_on; // see R9
        end
    end

    // pin radio control: synchronise, then edge detect on the second stage
    logic [1:0] pin_meta_r;
    logic [1:0] pin_sync_r;
    logic [1:0] pin_prev_r;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_meta_r <= 2'b00;
            pin_sync_r <= 2'b00;
            pin_prev_r <= 2'b00;
        end else begin
            pin_meta_r <= {pin_tx_req, pin_rx_req};
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_rx_go <= 1'b0;
            pin_tx_go <= 1'b0;
        end else begin
            pin_rx_go <= pin_ctrl_en && pin_sync_r[0] && !pin_prev_r[0]; // see R8
            pin_tx_go <= pin_ctrl_en && pin_sync_r[1] && !pin_prev_r[1]; // see R8
        end
    end

    assign pin_ctrl_active = pin_ctrl_en;

    // carrier sense seen since this receive started; a new start rearms the freeze
    logic cs_seen_r;

    // a carrier in the same cycle as a new start counts for the new receive
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cs_seen_r <= 1'b0;
        end else if (carrier_sense) begin
            cs_seen_r <= 1'b1;
        end else if (rx_start) begin
            cs_seen_r <= 1'b0;
        end
    end

    assign loop_freeze = freeze_gate && !cs_seen_r && !carrier_sense; // see R10

    // loop gain in units of K/2: pre-sync (sel+1)*K, post-sync K/2 or unchanged
    logic [3:0] pre_gain;

    assign pre_gain = {1'b0, pre_k_sel + 2'h1, 1'b0} == 4'h0 ?
        4'h8 : {1'b0, pre_k_sel + 2'h1, 1'b0}; // see R11

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            comp_gain_half_k <= 4'h6;
        end else if (sync_found && post_k_half) begin
            comp_gain_half_k <= 4'h1; // see R12
        end else begin
            comp_gain_half_k <= pre_gain; // see R11
        end
    end

    // saturation: 00 turns compensation off, else clamp to bw/8, bw/4, bw/2
    logic [RCOC_OFS_W-1:0] bw_limit;
    logic signed [RCOC_OFS_W-1:0] lim_pos;
    logic signed [RCOC_OFS_W-1:0] lim_neg;

    always_comb begin
        case (limit_sel)
            2'h1: bw_limit = chan_bw >> 3;
            2'h2: bw_limit = chan_bw >> 2;
            2'h3: bw_limit = chan_bw >> 1;
            default: bw_limit = '0;
        endcase
    end

    assign lim_pos = $signed(bw_limit);
    assign lim_neg = -$signed(bw_limit);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            comp_enable <= 1'b0;
            ofs_applied <= '0;
        end else begin
            comp_enable <= (limit_sel != 2'h0); // see R13
            if (limit_sel == 2'h0) begin
                ofs_applied <= '0; // see R13
            end else if (ofs_estimate > lim_pos) begin
                ofs_applied <= lim_pos; // see R13
            end else if (ofs_estimate < lim_neg) begin
                ofs_applied <= lim_neg; // see R13
            end else begin
                ofs_applied <= ofs_estimate;
            end
        end
    end
endmodule : rcoc_cfg
`default_nettype wire

//--- bench/rcoc_checker.sv
/*
 * Assertion checker for rcoc_cfg; keeps shadow copies of both registers
 * from the write port.
 * Assumes it is bound to rcoc_cfg and that writes take effect next cycle.
 */
`timescale 1ns/10ps
`default_nettype none
module rcoc_checker
    import rcoc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic calibrate_strobe,
    input wire logic evt_idle_to_active,
    input wire logic evt_auto_return_idle,
    input wire logic in_sleep_state,
    input wire logic cal_start,
    input wire logic xosc_stable,
    input wire logic xosc_enable,
    input wire logic chip_ready_indicator_n,
    input wire logic pin_rx_go,
    input wire logic pin_tx_go,
    input wire logic pin_ctrl_active,
    input wire logic carrier_sense,
    input wire logic sync_found,
    input wire logic loop_freeze,
    input wire logic [3:0] comp_gain_half_k,
    input wire logic comp_enable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic [7:0] sm_r;
    logic [7:0] foc_r;
    logic [1:0] ret_r;
    logic [16:0] up_r;
    logic [8:0] po_exp;
    logic wrap;
    logic osc_exp;
    logic lim_on;
    logic [3:0] gain_exp;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sm_r <= RCOC_SM_CFG0_RST;
            foc_r <= RCOC_FOC_CFG_RST;
        end else if (reg_wr_en && reg_addr == RCOC_ADDR_SM_CFG0) begin
            sm_r <= reg_wr_data & RCOC_SM_CFG0_MASK;
        end else if (reg_wr_en && reg_addr == RCOC_ADDR_FOC_CFG) begin
            foc_r <= reg_wr_data & RCOC_FOC_CFG_MASK;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ret_r <= 2'h0;
        end else if (sm_r[5:4] == 2'h3 && evt_auto_return_idle) begin
            ret_r <= ret_r + 2'h1;
        end
    end
    // saturates so a long-stable oscillator never looks fresh again
    always_ff @(posedge clk_sys) begin
        if (srst || !xosc_stable) begin
            up_r <= 17'h00000;
        end else if (up_r != 17'h1FFFF) begin
            up_r <= up_r + 17'h00001;
        end
    end
    // one expiry is 64 ripple steps of 4 cycles, so 256 cycles
    assign po_exp = sm_r[3] ? (sm_r[2] ? RCOC_PO_EXP_3 : RCOC_PO_EXP_2)
        : (sm_r[2] ? RCOC_PO_EXP_1 : RCOC_PO_EXP_0);
    assign wrap = evt_auto_return_idle && ret_r == 2'h3;
    assign osc_exp = !in_sleep_state || sm_r[0];
    assign lim_on = foc_r[1:0] != 2'h0;
    assign gain_exp = (sync_found && foc_r[2]) ? 4'h1 : {1'b0, foc_r[4:3], 1'b0} + 4'h2;
    property p_cal_never; sm_r[5:4] == 2'h0 |=> cal_start == $past(calibrate_strobe);
    endproperty
    a_cal_never: assert property (p_cal_never) else $error("cal mismatch in manual mode");
    property p_cal_entry;
        sm_r[5:4] == 2'h1 |=> cal_start == $past(evt_idle_to_active || calibrate_strobe);
    endproperty
    a_cal_entry: assert property (p_cal_entry) else $error("cal mismatch in entry mode");
    property p_cal_ret;
        sm_r[5:4] == 2'h2 |=> cal_start == $past(evt_auto_return_idle || calibrate_strobe);
    endproperty
    a_cal_ret: assert property (p_cal_ret) else $error("cal mismatch in return mode");
    property p_cal_4th; sm_r[5:4] == 2'h3 |=> cal_start == $past(wrap || calibrate_strobe);
    endproperty
    a_cal_4th: assert property (p_cal_4th) else $error("cal mismatch in fourth mode");
    property p_po_wait; $fell(chip_ready_indicator_n) |-> up_r >= {po_exp, 8'h00}; endproperty
    a_po_wait: assert property (p_po_wait) else $error("chip ready too early");
    property p_pin; (pin_rx_go || pin_tx_go) |-> $past(pin_ctrl_active && sm_r[1]); endproperty
    a_pin: assert property (p_pin) else $error("pin request while pin control off");
    property p_osc; 1'b1 |=> xosc_enable == $past(osc_exp); endproperty
    a_osc: assert property (p_osc) else $error("oscillator enable wrong");
    property p_freeze; (carrier_sense || !foc_r[5]) |-> !loop_freeze; endproperty
    a_freeze: assert property (p_freeze) else $error("loop frozen without cause");
    property p_gain; 1'b1 |=> comp_gain_half_k == $past(gain_exp); endproperty
    a_gain: assert property (p_gain) else $error("loop gain wrong");
    property p_limit; 1'b1 |=> comp_enable == $past(lim_on); endproperty
    a_limit: assert property (p_limit) else $error("compensation enable wrong");
endmodule : rcoc_checker
bind rcoc_cfg rcoc_checker chk_u (.clk_sys, .srst, .reg_addr, .reg_wr_en, .reg_wr_data,
    .calibrate_strobe, .evt_idle_to_active, .evt_auto_return_idle, .in_sleep_state,
    .cal_start, .xosc_stable, .xosc_enable, .chip_ready_indicator_n, .pin_rx_go, .pin_tx_go,
    .pin_ctrl_active, .carrier_sense, .sync_found, .loop_freeze, .comp_gain_half_k,
    .comp_enable);
`default_nettype wire

//--- bench/testbench.sv
/*
 * Self-checking bench for rcoc_cfg: register tasks and event drivers.
 * Assumes a 100 MHz clock; inputs change at the falling edge.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench
    import rcoc_pkg::*;
;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wr_data = 8'h00;
    logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, calibrate_strobe = 1'b0;
    logic evt_idle_to_active = 1'b0, evt_auto_return_idle = 1'b0, in_sleep_state = 1'b1;
    logic xosc_stable = 1'b0, pin_rx_req = 1'b0, pin_tx_req = 1'b0, rx_start = 1'b0;
    logic carrier_sense = 1'b0, sync_found = 1'b0;
    logic signed [RCOC_OFS_W-1:0] ofs_estimate = 12'h000;
    logic [RCOC_OFS_W-1:0] chan_bw = 12'h320;
    logic [7:0] reg_rd_data;
    logic cal_start, xosc_enable, chip_ready_indicator_n, pin_rx_go, pin_tx_go;
    logic pin_ctrl_active, loop_freeze, comp_enable;
    logic [3:0] comp_gain_half_k;
    logic signed [RCOC_OFS_W-1:0] ofs_applied;
    logic [5:0] cal_v;
    // the manual strobe calibrates in every mode
    logic [5:0] exp_cal [4] = '{6'h01, 6'h03, 6'h3D, 6'h21};
    int mismatches = 0;
    int checks_done = 0;
    int n;
    always #5 clk_sys = ~clk_sys;
    rcoc_cfg dut_u (.clk_sys, .srst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
        .reg_rd_data, .calibrate_strobe, .evt_idle_to_active, .evt_auto_return_idle,
        .in_sleep_state, .cal_start, .xosc_stable, .xosc_enable, .chip_ready_indicator_n,
        .pin_rx_req, .pin_tx_req, .pin_rx_go, .pin_tx_go, .pin_ctrl_active, .rx_start,
        .carrier_sense, .sync_found, .ofs_estimate, .chan_bw, .loop_freeze,
        .comp_gain_half_k, .comp_enable, .ofs_applied);
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk_sys);
        reg_rd_en = 1'b0;
        chk("rd_data", {4'h0, e}, {4'h0, reg_rd_data});
    endtask : rd
    task automatic fire(input int k);
        @(negedge clk_sys);
        calibrate_strobe = (k == 0);
        evt_idle_to_active = (k == 1);
        evt_auto_return_idle = (k == 2);
        @(negedge clk_sys);
        cal_v = {cal_start, cal_v[5:1]};
        calibrate_strobe = 1'b0;
        evt_idle_to_active = 1'b0;
        evt_auto_return_idle = 1'b0;
    endtask : fire
    // the window allows for synchroniser and output register latency
    task automatic po(input logic [1:0] sel, input int e);
        wr(RCOC_ADDR_SM_CFG0, {4'h0, sel, 2'h0});
        xosc_stable = 1'b1;
        n = 0;
        while (chip_ready_indicator_n !== 1'b0 && n < e + 40) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= e + 40) begin
            mismatches++;
            end_sim();
        end
        chk("po_time", 12'h001, {11'h0, n >= e && n <= e + 10});
        xosc_stable = 1'b0;
        repeat (6) @(negedge clk_sys);
        chk("po_restart", 12'h001, {11'h0, chip_ready_indicator_n});
    endtask : po
    task automatic pin(input logic en);
        wr(RCOC_ADDR_SM_CFG0, {6'h0, en, 1'b0});
        chk("pin_act", {11'h0, en}, {11'h0, pin_ctrl_active});
        chk("osc_sleep", 12'h000, {11'h0, xosc_enable});
        n = 0;
        pin_rx_req = 1'b1;
        repeat (8) @(negedge clk_sys) n += (pin_rx_go === 1'b1);
        pin_tx_req = 1'b1;
        repeat (8) @(negedge clk_sys) n += 16 * (pin_tx_go === 1'b1);
        pin_rx_req = 1'b0;
        pin_tx_req = 1'b0;
        repeat (6) @(negedge clk_sys);
        chk("pin_go", en ? 12'h011 : 12'h000, 12'(n));
    endtask : pin
    initial begin
        repeat (12) @(negedge clk_sys);
        srst = 1'b0;
        @(negedge clk_sys);
        chk("freeze_rst", 12'h001, {11'h0, loop_freeze});
        carrier_sense = 1'b1;
        @(negedge clk_sys);
        chk("freeze_cs", 12'h000, {11'h0, loop_freeze});
        carrier_sense = 1'b0;
        @(negedge clk_sys);
        chk("freeze_held", 12'h000, {11'h0, loop_freeze});
        rx_start = 1'b1;
        @(negedge clk_sys);
        rx_start = 1'b0;
        @(negedge clk_sys);
        chk("freeze_rearm", 12'h001, {11'h0, loop_freeze});
        rd(RCOC_ADDR_SM_CFG0, RCOC_SM_CFG0_RST);
        rd(RCOC_ADDR_FOC_CFG, RCOC_FOC_CFG_RST);
        rd(6'h1A, 8'h00);
        wr(RCOC_ADDR_SM_CFG0, 8'hFF);
        rd(RCOC_ADDR_SM_CFG0, 8'h3F);
        for (int m = 0; m < 4; m++) begin
            wr(RCOC_ADDR_SM_CFG0, 8'(m * 16));
            cal_v = 6'h00;
            fire(0);
            fire(1);
            repeat (4) fire(2);
            chk("cal", {6'h0, exp_cal[m]}, {6'h0, cal_v});
        end
        pin(1'b1);
        pin(1'b0);
        wr(RCOC_ADDR_SM_CFG0, 8'h01);
        @(negedge clk_sys);
        chk("osc_keep", 12'h001, {11'h0, xosc_enable});
        in_sleep_state = 1'b0;
        wr(RCOC_ADDR_SM_CFG0, 8'h00);
        @(negedge clk_sys);
        chk("osc_awake", 12'h001, {11'h0, xosc_enable});
        in_sleep_state = 1'b1;
        po(2'h0, 256);
        po(2'h1, 4096);
        po(2'h2, 16384);
        for (int p = 0; p < 4; p++) begin
            wr(RCOC_ADDR_FOC_CFG, 8'(p * 8 + 4));
            sync_found = 1'b0;
            repeat (2) @(negedge clk_sys);
            chk("gain_pre", 12'(2 * p + 2), {8'h0, comp_gain_half_k});
            sync_found = 1'b1;
            repeat (2) @(negedge clk_sys);
            chk("gain_post", 12'h001, {8'h0, comp_gain_half_k});
            wr(RCOC_ADDR_FOC_CFG, 8'(p * 8));
            @(negedge clk_sys);
            chk("gain_keep", 12'(2 * p + 2), {8'h0, comp_gain_half_k});
        end
        for (int l = 0; l < 4; l++) begin
            wr(RCOC_ADDR_FOC_CFG, 8'(l));
            ofs_estimate = 12'h032;
            repeat (2) @(negedge clk_sys);
            chk("sat_pass", l == 0 ? 12'h000 : 12'h032, ofs_applied);
            ofs_estimate = 12'h1F4;
            repeat (2) @(negedge clk_sys);
            chk("sat_pos", l == 0 ? 12'h000 : 12'h320 >> (4 - l), ofs_applied);
            chk("comp_en", {11'h0, l != 0}, {11'h0, comp_enable});
            ofs_estimate = 12'hE0C;
            repeat (2) @(negedge clk_sys);
            chk("sat_neg", l == 0 ? 12'h000 : -(12'h320 >> (4 - l)), ofs_applied);
        end
        end_sim();
    end
endmodule : testbench
`default_nettype wire
